// >>> cmd_buf_map.svh
`ifndef CMD_BUF_MAP_SVH
`define CMD_BUF_MAP_SVH

// bit n of a mask is input n of the [25:1] data bus
`define PAR_MASK_SINGLE 25'h1FFFFB6
`define PAR_MASK_DUAL_A 25'h0003FB6
`define PAR_MASK_DUAL_B 25'h0001BBF

// edges the error line stays low once it has fallen
`define ERR_HOLD_CYCLES 2'h2

`define DATA_RESET 25'h0000000
`define BIT_RESET 1'h0
`define ERR_N_RESET 1'h1
`define HOLD_RESET 2'h0

`endif

// >>> cmd_buf_pkg.sv
package cmd_buf_pkg;
`include "cmd_buf_map.svh"

   typedef enum logic [1:0] {MODE_SINGLE, MODE_DUAL_A, MODE_DUAL_B} fanout_mode_t;

   typedef logic [25:1] cmd_word_t;

   function automatic fanout_mode_t mode_of(input logic fanout_sel, input logic pair_sel);
      fanout_mode_t m;
      m = MODE_SINGLE;
      if (fanout_sel)
      begin
         m = pair_sel ? MODE_DUAL_B : MODE_DUAL_A;
      end
      return m;
   endfunction

   function automatic cmd_word_t parity_mask(input fanout_mode_t m);
      cmd_word_t k;
      k = `PAR_MASK_SINGLE;
      unique case (m)
         MODE_SINGLE: k = `PAR_MASK_SINGLE;
         MODE_DUAL_A: k = `PAR_MASK_DUAL_A;
         MODE_DUAL_B: k = `PAR_MASK_DUAL_B;
      endcase
      return k;
   endfunction

endpackage

// >>> parity_if.sv
`timescale 1ns/100ps
interface parity_if;
   logic data_parity;
   logic data_valid;

   modport source (output data_parity, output data_valid);
   modport checker_end (input data_parity, input data_valid);
endinterface

// >>> late_parity_checker.sv
`timescale 1ns/100ps
module late_parity_checker
   import cmd_buf_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_pair_select,
   input wire logic i_late_parity_in,
   parity_if.checker_end pif,
   output logic o_partial_parity_out,
   output logic o_parity_error_n,
   output logic o_parity_error_oe
);
   import cmd_buf_pkg::*;

   logic s1_par_q, s1_par_d, s1_val_q, s1_val_d;
   logic s2_par_q, s2_par_d, s2_val_q, s2_val_d;
   logic ppo_q, ppo_d, err_n_q, err_n_d, oe_q, oe_d;
   logic [1:0] hold_q, hold_d;
   logic sel_par, sel_val, odd;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      s1_par_d = pif.data_parity;
      s1_val_d = pif.data_valid;
      s2_par_d = s1_par_q;
      s2_val_d = s1_val_q;
      // late parity lands one edge after its data, or two in the b layout
      sel_par = i_pair_select ? s2_par_q : s1_par_q;
      sel_val = i_pair_select ? s2_val_q : s1_val_q;
      odd = sel_par ^ i_late_parity_in;
      ppo_d = ppo_q;
      err_n_d = err_n_q;
      hold_d = hold_q;
      if (hold_q != `HOLD_RESET)
      begin
         hold_d = hold_q - 2'h1;
      end
      if (sel_val)
      begin
         ppo_d = odd;
         if (hold_q == `HOLD_RESET)
         begin
            err_n_d = !odd;
            if (odd)
            begin
               hold_d = `ERR_HOLD_CYCLES - 2'h1;
            end
         end
      end
      oe_d = !err_n_d;
   end

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         s1_par_q <= `BIT_RESET;
         s1_val_q <= `BIT_RESET;
         s2_par_q <= `BIT_RESET;
         s2_val_q <= `BIT_RESET;
         ppo_q <= `BIT_RESET;
         err_n_q <= `ERR_N_RESET;
         oe_q <= `BIT_RESET;
         hold_q <= `HOLD_RESET;
      end
      else
      begin
         s1_par_q <= s1_par_d;
         s1_val_q <= s1_val_d;
         s2_par_q <= s2_par_d;
         s2_val_q <= s2_val_d;
         ppo_q <= ppo_d;
         err_n_q <= err_n_d;
         oe_q <= oe_d;
         hold_q <= hold_d;
      end
   end

   assign o_partial_parity_out = ppo_q;
   assign o_parity_error_n = err_n_q;
   assign o_parity_error_oe = oe_q;

   ////////////////////////////////////////////////////////////////////////////
   a_ppo_one_late: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (!i_pair_select && pif.data_valid) ##1 !i_pair_select
      |=> o_partial_parity_out == ($past(pif.data_parity, 2) ^ $past(i_late_parity_in)))
      else $error("parity output wrong at one edge latency");

   a_ppo_two_late: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_pair_select && pif.data_valid) ##1 i_pair_select ##1 i_pair_select
      |=> o_partial_parity_out == ($past(pif.data_parity, 3) ^ $past(i_late_parity_in)))
      else $error("parity output wrong at two edge latency");

   a_ppo_gated_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      !sel_val |=> $stable(o_partial_parity_out))
      else $error("parity output moved without a selected crossing");

   a_error_on_odd: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (sel_val && odd) |=> !o_parity_error_n)
      else $error("error line not low after odd parity");

   a_error_held_two: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      $fell(o_parity_error_n) |=> !o_parity_error_n)
      else $error("error line released before two cycles");

   a_error_release: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (sel_val && !odd && hold_q == `HOLD_RESET) |=> o_parity_error_n)
      else $error("error line not released on even parity");

   a_drive_enable: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_parity_error_oe == !o_parity_error_n)
      else $error("open drain enable disagrees with error level");

endmodule // late_parity_checker

// >>> registered_cmd_buffer.sv
`timescale 1ns/100ps
// What this block does
// - inputs are sampled only at the rising crossing of the clock
// - reset low clears everything: outputs low, parity low, error released high
// - both chip selects high freeze data outputs; otherwise they load sampled data
// - select output loads the primary chip select every crossing
// - termination and clock enable outputs load every crossing, never gated
// - with reset high and no crossing every output keeps its level
// - partial parity is masked data xor late parity; held when both selects high
// - parity covers a different input set in each of the three layouts
// - late parity comes one edge after data, two in the b layout
// - open-drain error goes low one cycle after data on odd parity, two cycles in the b layout
// - a low error stays low for two cycles unless reset
// - fanout select picks single or dual copies; pair select picks a or b
// - the parity and error outputs of this device carry the checked result
module registered_cmd_buffer
   import cmd_buf_pkg::*;
#(
   parameter int DATA_W = 25
)
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_fanout_select,
   input wire logic i_pair_select,
   input wire logic [DATA_W:1] i_cmd_addr_in,
   input wire logic i_primary_select_n,
   input wire logic i_secondary_select_n,
   input wire logic i_termination_ctrl_in,
   input wire logic i_clock_enable_in,
   input wire logic i_late_parity_in,
   output logic [DATA_W:1] o_cmd_addr_out_a,
   output logic [DATA_W:1] o_cmd_addr_out_b,
   output logic o_select_out_a,
   output logic o_select_out_b,
   output logic o_termination_ctrl_out_a,
   output logic o_termination_ctrl_out_b,
   output logic o_clock_enable_out_a,
   output logic o_clock_enable_out_b,
   output logic o_partial_parity_out,
   output logic o_parity_error_n,
   output logic o_parity_error_oe
);
   import cmd_buf_pkg::*;

   fanout_mode_t mode;
   logic dual, cs_any;
   logic [DATA_W:1] qa_q, qa_d, qb_q, qb_d;
   logic csa_q, csa_d, csb_q, csb_d;
   logic odta_q, odta_d, odtb_q, odtb_d;
   logic ckea_q, ckea_d, ckeb_q, ckeb_d;

   parity_if pif ();

   ////////////////////////////////////////////////////////////////////////////
   // configuration pins are expected static; they are decoded every cycle anyway
   always_comb
   begin
      mode = mode_of(i_fanout_select, i_pair_select);
      dual = (mode != MODE_SINGLE);
      cs_any = !i_primary_select_n || !i_secondary_select_n;
      qa_d = cs_any ? i_cmd_addr_in : qa_q;
      // b copies are dark in single mode, mirrors of a in dual mode
      qb_d = dual ? qa_d : `DATA_RESET;
      csa_d = i_primary_select_n;
      csb_d = dual ? csa_d : `BIT_RESET;
      odta_d = i_termination_ctrl_in;
      odtb_d = dual ? odta_d : `BIT_RESET;
      ckea_d = i_clock_enable_in;
      ckeb_d = dual ? ckea_d : `BIT_RESET;
   end

   // one edge stands for the crossing; only reset low moves anything without it
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         qa_q <= `DATA_RESET;
         qb_q <= `DATA_RESET;
         csa_q <= `BIT_RESET;
         csb_q <= `BIT_RESET;
         odta_q <= `BIT_RESET;
         odtb_q <= `BIT_RESET;
         ckea_q <= `BIT_RESET;
         ckeb_q <= `BIT_RESET;
      end
      else
      begin
         qa_q <= qa_d;
         qb_q <= qb_d;
         csa_q <= csa_d;
         csb_q <= csb_d;
         odta_q <= odta_d;
         odtb_q <= odtb_d;
         ckea_q <= ckea_d;
         ckeb_q <= ckeb_d;
      end
   end

   assign o_cmd_addr_out_a = qa_q;
   assign o_cmd_addr_out_b = qb_q;
   assign o_select_out_a = csa_q;
   assign o_select_out_b = csb_q;
   assign o_termination_ctrl_out_a = odta_q;
   assign o_termination_ctrl_out_b = odtb_q;
   assign o_clock_enable_out_a = ckea_q;
   assign o_clock_enable_out_b = ckeb_q;

   ////////////////////////////////////////////////////////////////////////////
   // parity of the sampled word is taken from the raw inputs so it lines up
   // with the data edge, not with the held output word
   assign pif.data_parity = ^(i_cmd_addr_in & parity_mask(mode));
   assign pif.data_valid = cs_any;

   late_parity_checker u_checker (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_pair_select(i_pair_select),
      .i_late_parity_in(i_late_parity_in),
      .pif(pif),
      .o_partial_parity_out(o_partial_parity_out),
      .o_parity_error_n(o_parity_error_n),
      .o_parity_error_oe(o_parity_error_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   a_reset_forces_low: assert property (@(posedge i_mclk)
      !i_rst_b |-> (qa_q == `DATA_RESET && !csa_q && !odta_q && !ckea_q
                    && !o_partial_parity_out && o_parity_error_n))
      else $error("outputs not cleared under reset");

   a_gate_holds_data: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_primary_select_n && i_secondary_select_n) |=> $stable(o_cmd_addr_out_a))
      else $error("data outputs moved with both selects high");

   a_data_follows: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      cs_any |=> o_cmd_addr_out_a == $past(i_cmd_addr_in))
      else $error("data outputs did not load sampled input");

   a_select_follows: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      1'b1 |=> o_select_out_a == $past(i_primary_select_n))
      else $error("select output not loaded from primary select");

   a_term_cke_ungated: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_primary_select_n && i_secondary_select_n)
      |=> (o_termination_ctrl_out_a == $past(i_termination_ctrl_in)
           && o_clock_enable_out_a == $past(i_clock_enable_in)))
      else $error("termination or clock enable was gated");

   a_copies_match: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      dual |=> (o_cmd_addr_out_b == o_cmd_addr_out_a && o_select_out_b == o_select_out_a
                && o_clock_enable_out_b == o_clock_enable_out_a
                && o_termination_ctrl_out_b == o_termination_ctrl_out_a))
      else $error("dual copies differ");

   a_single_b_dark: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      !dual |=> (o_cmd_addr_out_b == `DATA_RESET && !o_select_out_b))
      else $error("b copies driven in single mode");

   a_exit_stays_low: assert property (@(posedge i_mclk)
      (!i_rst_b ##1 i_rst_b) |-> (o_cmd_addr_out_a == `DATA_RESET && !o_select_out_a))
      else $error("outputs not low at reset exit");

endmodule // registered_cmd_buffer

// >>> cmd_ctrl_model.sv
`timescale 1ns/100ps
module cmd_ctrl_model
   import cmd_buf_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_pair_select,
   input wire cmd_buf_pkg::cmd_word_t i_mask,
   input wire cmd_buf_pkg::cmd_word_t i_word,
   input wire logic i_bad,
   output logic o_late_parity
);
   logic stage1_q;
   logic stage2_q;
   logic stage1_d;
   logic stage2_d;
   ////////////////////////////////////////////////////////////////////////////////
   // controller sends even parity; i_bad flips it on purpose to provoke an error
   always_comb
   begin
      stage1_d = (^(i_word & i_mask)) ^ i_bad;
      stage2_d = stage1_q;
   end
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         stage1_q <= 1'h0;
         stage2_q <= 1'h0;
      end
      else
      begin
         stage1_q <= stage1_d;
         stage2_q <= stage2_d;
      end
   end
   // late bit trails its data by one edge, two in layout b
   assign o_late_parity = i_pair_select ? stage2_q : stage1_q;
endmodule // cmd_ctrl_model

// >>> ddr2_registered_cmd_buffer_parity_test.sv
`timescale 1ns/100ps
module ddr2_registered_cmd_buffer_parity_test;
   import cmd_buf_pkg::*;
   logic i_mclk = 1'h0;
   logic i_rst_b = 1'h1;
   logic fan = 1'h0;
   logic pair = 1'h0;
   cmd_word_t word = '0;
   cmd_word_t msk = '0;
   logic ps_n = 1'h1;
   logic ss_n = 1'h1;
   logic odt = 1'h0;
   logic cke = 1'h0;
   logic bad = 1'h0;
   logic lp;
   cmd_word_t oa, ob;
   logic sa, sb, ta, tb, ca, cb, partial_parity_out, err_n, oe;
   cmd_word_t eq;
   logic es, eo, ek, ep, ee, v1, v2, x1, x2, vr, xr;
   int hold;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   ////////////////////////////////////////////////////////////////////////////////
   always #5 i_mclk = ~i_mclk;
   registered_cmd_buffer u_registered_cmd_buffer (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
      .i_fanout_select(fan), .i_pair_select(pair), .i_cmd_addr_in(word),
      .i_primary_select_n(ps_n), .i_secondary_select_n(ss_n), .i_termination_ctrl_in(odt),
      .i_clock_enable_in(cke), .i_late_parity_in(lp), .o_cmd_addr_out_a(oa),
      .o_cmd_addr_out_b(ob), .o_select_out_a(sa), .o_select_out_b(sb),
      .o_termination_ctrl_out_a(ta), .o_termination_ctrl_out_b(tb),
      .o_clock_enable_out_a(ca), .o_clock_enable_out_b(cb), .o_partial_parity_out(partial_parity_out),
      .o_parity_error_n(err_n), .o_parity_error_oe(oe));
   cmd_ctrl_model u_cmd_ctrl_model (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_pair_select(pair),
      .i_mask(msk), .i_word(word), .i_bad(bad), .o_late_parity(lp));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic cmd_word_t mask_for(input int m);
      cmd_word_t k;
      k = '0;
      for (int n = 1; n <= 25; n++)
      begin
         if (m == 2) k[n] = (n <= 6) || (n >= 8 && n <= 10) || n == 12 || n == 13;
         else k[n] = (n >= 8 || n == 2 || n == 3 || n == 5 || n == 6) && (m == 0 || n <= 14);
      end
      return k;
   endfunction
   task automatic close_out;
      if (error_cnt == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // reference: inputs are read before the bench's nonblocking updates land
   always @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         {eq, es, eo, ek, ep, v1, v2, x1, x2} = '0;
         ee = 1'h1;
         hold = 0;
      end
      else
      begin
         if (!(ps_n && ss_n)) eq = word;
         {es, eo, ek} = {ps_n, odt, cke};
         vr = pair ? v2 : v1;
         xr = pair ? x2 : x1;
         {v2, x2} = {v1, x1};
         {v1, x1} = {!(ps_n && ss_n), ^(word & msk)};
         if (vr) ep = xr ^ lp;
         if (hold > 0) hold--;
         else if (vr)
         begin
            ee = !(xr ^ lp);
            hold = ee ? 0 : 1;
         end
      end
   end
   always @(negedge i_mclk)
   begin
      if (i_rst_b)
      begin
         chk(oa, eq);
         chk(ob, fan ? eq : '0);
         chk({sa, sb}, {es, fan & es});
         chk({ta, tb, ca, cb}, {eo, fan & eo, ek, fan & ek});
         chk(partial_parity_out, ep);
         chk(err_n, ee);
         chk(oe, !ee);
      end
   end
   // ceiling well above the three passes of about 310 cycles each
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      // a real falling edge at time zero so the asynchronous clears act before the first clock
      i_rst_b <= 1'h0;
      void'($urandom(32'hd13a));
      for (int m = 0; m < 3; m++)
      begin
         fan <= (m > 0);
         pair <= (m == 2);
         msk <= mask_for(m);
         repeat (8) @(posedge i_mclk);
         i_rst_b <= 1'h1;
         for (int i = 0; i < 300; i++)
         begin
            @(posedge i_mclk);
            word <= ((i % 50 == 7) ? '1 : cmd_word_t'($urandom))
               & ((m > 0) ? 25'h0003FFF : 25'h1FFFFFF);
            ps_n <= 1'($urandom % 2);
            ss_n <= (i >= 100 && i < 104) ? 1'h1 : 1'($urandom % 2);
            {odt, cke} <= 2'($urandom);
            bad <= (i >= 100 && i < 104) || ($urandom % 4 == 0);
         end
         // asynchronous reset in mid-traffic must clear outputs without a clock edge
         @(posedge i_mclk);
         i_rst_b <= 1'h0;
         {word, ps_n, ss_n, odt, cke, bad} <= '0;
         #1;
         chk(oa, 32'h0);
         chk(ob, 32'h0);
         chk({sa, sb, ta, tb, ca, cb, partial_parity_out, err_n, oe}, 32'h002);
      end
      close_out();
   end
endmodule // ddr2_registered_cmd_buffer_parity_test
